/* File: dv/brac_slave_model.sv */
// Slave models behind the two checked ports.
`timescale 1ns/1ns
module brac_slave_model import brac_pkg::*; (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Answer pacing per port.
	input wire logic [NUM_PORTS-1:0][3:0] wait_cycles,
	// Slave side.
	input wire logic [NUM_PORTS-1:0] s_valid,
	input wire logic [NUM_PORTS-1:0][ADDR_W-1:0] s_addr,
	input wire logic [NUM_PORTS-1:0][DATA_W-1:0] s_wdata,
	output logic [NUM_PORTS-1:0] s_ready,
	output logic [NUM_PORTS-1:0][DATA_W-1:0] s_rdata,
	// Record of accepted transfers.
	output logic [NUM_PORTS-1:0][7:0] seen,
	output logic [NUM_PORTS-1:0][ADDR_W-1:0] last_addr,
	output logic [NUM_PORTS-1:0][DATA_W-1:0] last_wdata
);
	logic [NUM_PORTS-1:0][3:0] cnt_reg;

	// Read data toggles in every cycle that no request is waiting, so a late capture by the checker shows up.
	always_ff @(posedge sys_clk) begin
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (sys_rst) begin
				s_ready[p] <= 1'b0;
				cnt_reg[p] <= 4'h0;
				seen[p] <= 8'h0;
				s_rdata[p] <= '0;
			end else if (s_valid[p] && !s_ready[p] && cnt_reg[p] == wait_cycles[p]) begin
				s_ready[p] <= 1'b1;
				cnt_reg[p] <= 4'h0;
				s_rdata[p] <= {s_addr[p], ~s_addr[p]};
				seen[p] <= seen[p] + 8'h1;
				last_addr[p] <= s_addr[p];
				last_wdata[p] <= s_wdata[p];
			end else if (s_valid[p] && !s_ready[p]) begin
				cnt_reg[p] <= cnt_reg[p] + 4'h1;
			end else begin
				s_ready[p] <= 1'b0;
				s_rdata[p] <= ~s_rdata[p];
			end
		end
	end
endmodule : brac_slave_model

/* File: dv/brac_top_asserts.sv */
// Concurrent checks on the ports of the bus region access checker.
`timescale 1ns/1ns
module brac_top_asserts import brac_pkg::*; #(
	parameter int NUM_REGIONS = MAX_REGIONS
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Protection and descriptors.
	input wire logic prot_enable,
	input wire logic prot_active,
	input wire logic desc_wr_en,
	input wire logic [3:0] desc_wr_idx,
	input wire logic [1:0] desc_wr_word,
	input wire logic [31:0] desc_wr_data,
	input wire logic [NUM_REGIONS-1:0] desc_valid,
	// Master side.
	input wire logic [NUM_PORTS-1:0] m_valid,
	input wire logic [NUM_PORTS-1:0][ADDR_W-1:0] m_addr,
	input wire logic [NUM_PORTS-1:0] m_busy,
	input wire logic [NUM_PORTS-1:0] m_done,
	input wire logic [NUM_PORTS-1:0] m_err,
	// Slave side.
	input wire logic [NUM_PORTS-1:0] s_valid,
	input wire logic [NUM_PORTS-1:0][ADDR_W-1:0] s_addr,
	input wire logic [NUM_PORTS-1:0][DATA_W-1:0] s_wdata,
	input wire logic [NUM_PORTS-1:0] s_ready,
	// Fault reporting.
	input wire logic [NUM_PORTS-1:0][REC_W-1:0] err_record,
	input wire logic [NUM_PORTS-1:0] fault_flag,
	input wire logic [NUM_PORTS-1:0] fault_clr
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	// A request taken on port 0 is forwarded to the slave or refused with an error two edges later.
	answer_timing_a: assert property (
		m_valid[0] && !m_busy[0] |=> m_busy[0] ##1 (s_valid[0] || m_err[0]))
		else $error("transfer not forwarded or refused in time");
	error_blocks_slave_a: assert property (
		|m_err |-> ((m_err & ~m_done) == '0) && ((m_err & s_valid) == '0))
		else $error("refused transfer reached the slave");
	ready_done_a: assert property (
		s_valid[0] && s_ready[0] |=> m_done[0] && !m_err[0] && !s_valid[0])
		else $error("slave completion not answered");
	slave_hold_a: assert property (
		s_valid[0] && !s_ready[0] |=> s_valid[0] && $stable(s_addr[0]) && $stable(s_wdata[0]))
		else $error("slave request changed before completion");
	done_pulse_a: assert property (m_done[1] |=> !m_done[1])
		else $error("answer longer than one cycle");
	fault_record_a: assert property (
		m_done[1] && m_err[1] |-> fault_flag[1] && err_record[1][31:0] == $past(m_addr[1], 2))
		else $error("fault record not captured");
	flag_sticky_a: assert property (fault_flag[0] && !fault_clr[0] |=> fault_flag[0])
		else $error("fault flag dropped without clear");
	prot_on_a: assert property (prot_enable [*2] |=> prot_active)
		else $error("protection not active after enable");
	valid_set_a: assert property (
		desc_wr_en && desc_wr_idx == 4'h0 && desc_wr_word == WD_CTRL ##1 !desc_wr_en
		|=> desc_valid[0] == $past(desc_wr_data[0], 2))
		else $error("valid bit not set by control write");
endmodule : brac_top_asserts

bind brac_top brac_top_asserts #(.NUM_REGIONS(NUM_REGIONS)) u_asserts (.*);

/* File: dv/brac_top_tb.sv */
// Self-checking bench for the bus region access checker.
`timescale 1ns/1ns
module brac_top_tb import brac_pkg::*;;
	logic sys_clk, sys_rst, prot_enable, prot_active, desc_wr_en, acw_wr_en;
	logic [3:0] desc_wr_idx, acw_wr_idx;
	logic [1:0] desc_wr_word;
	logic [31:0] desc_wr_data, acw_wr_data;
	logic [15:0] desc_valid;
	logic [NUM_PORTS-1:0] m_valid, m_write, m_super, m_ifetch, m_busy, m_done, m_err;
	logic [NUM_PORTS-1:0] s_valid, s_write, s_ready, fault_flag, fault_clr;
	logic [NUM_PORTS-1:0][ADDR_W-1:0] m_addr, s_addr, last_addr;
	logic [NUM_PORTS-1:0][1:0] m_master;
	logic [NUM_PORTS-1:0][DATA_W-1:0] m_wdata, m_rdata, s_wdata, s_rdata, last_wdata;
	logic [NUM_PORTS-1:0][REC_W-1:0] err_record;
	logic [NUM_PORTS-1:0][7:0] seen;
	logic [NUM_PORTS-1:0][3:0] wait_cycles;
	int n_fail, checked;

	brac_top #(.NUM_REGIONS(16)) uut (.*);
	brac_slave_model slave (.*);

	// Clock at 125 MHz.
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	task automatic conclude;
		if (n_fail == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : conclude

	task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic dwr(input logic [3:0] idx, input logic [1:0] word, input logic [31:0] data);
		@(posedge sys_clk);
		desc_wr_en <= 1'b1;
		desc_wr_idx <= idx;
		desc_wr_word <= word;
		desc_wr_data <= data;
		@(posedge sys_clk);
		desc_wr_en <= 1'b0;
	endtask : dwr

	// Control word last, so the region only counts once it is whole.
	task automatic region(input logic [3:0] idx, input logic [31:0] lo, hi, acw);
		dwr(idx, 2'h0, lo);
		dwr(idx, 2'h1, hi);
		dwr(idx, 2'h2, acw);
		dwr(idx, 2'h3, 32'h1);
	endtask : region

	// One transfer; wsf holds write, supervisor and fetch from high to low.
	task automatic xfer(input int p, input logic [31:0] a, input logic [1:0] mst,
			input logic [2:0] wsf, input logic [15:0] hit, input logic err);
		logic [7:0] n0;
		n0 = seen[p];
		@(posedge sys_clk);
		m_valid[p] <= 1'b1;
		m_addr[p] <= a;
		m_master[p] <= mst;
		m_write[p] <= wsf[2];
		m_super[p] <= wsf[1];
		m_ifetch[p] <= wsf[0];
		m_wdata[p] <= {~a, a};
		@(posedge sys_clk);
		m_valid[p] <= 1'b0;
		for (int i = 0; i < 40 && m_done[p] !== 1'b1; i++) begin
			@(posedge sys_clk);
			#1;
		end
		chk("done", 64'h1, m_done[p]);
		chk("error", err, m_err[p]);
		if (err) begin
			chk("record", {8'h0, hit, 3'h0, wsf[0], wsf[1], wsf[2], mst, a}, err_record[p]);
			chk("flag", 64'h1, fault_flag[p]);
			chk("rdata", 64'h0, m_rdata[p]);
			chk("slave", n0, seen[p]);
		end else begin
			chk("slave", n0 + 8'h1, seen[p]);
			chk("s_addr", a, last_addr[p]);
			chk("s_write", wsf[2], s_write[p]);
			if (wsf[2]) chk("wdata", {~a, a}, last_wdata[p]);
			else chk("rdata", {a, ~a}, m_rdata[p]);
		end
	endtask : xfer

	// Main sequence.
	initial begin
		{sys_rst, prot_enable, desc_wr_en, acw_wr_en} = 4'hf - 4'h7;
		{desc_wr_idx, acw_wr_idx, desc_wr_word, desc_wr_data, acw_wr_data} = '0;
		{m_valid, m_write, m_super, m_ifetch, m_addr, m_master, m_wdata} = '0;
		{fault_clr, wait_cycles} = '0;
		repeat (10) @(posedge sys_clk);
		sys_rst <= 1'b0;
		#1;
		chk("valid", 64'h0, desc_valid);
		xfer(0, 32'h5000_0000, MST_CORE, 3'h0, 16'h0, 1'b0);
		region(4'h0, 32'h1000_0010, 32'h1000_0fe0, 32'h0000_004f);
		region(4'h1, 32'h2000_0000, 32'h2000_0000, 32'h0000_0e00);
		region(4'h2, 32'h1000_0800, 32'h1000_08e0, 32'h0000_0080);
		repeat (2) @(posedge sys_clk);
		#1;
		chk("valid", 64'h7, desc_valid);
		@(posedge sys_clk);
		prot_enable <= 1'b1;
		repeat (3) @(posedge sys_clk);
		xfer(0, 32'h1000_0004, MST_CORE, 3'h2, 16'h0, 1'b0);
		xfer(0, 32'h1000_0020, MST_CORE, 3'h3, 16'h0, 1'b0);
		xfer(0, 32'h1000_0000, MST_CORE, 3'h1, 16'h1, 1'b1);
		xfer(1, 32'h1000_0100, MST_CORE, 3'h4, 16'h1, 1'b1);
		xfer(0, 32'h1000_0810, MST_DMA, 3'h4, 16'h0, 1'b0);
		xfer(0, 32'h1000_0100, MST_DMA, 3'h4, 16'h1, 1'b1);
		xfer(1, 32'h2000_001f, MST_EXT, 3'h0, 16'h0, 1'b0);
		xfer(1, 32'h2000_0020, MST_EXT, 3'h0, 16'h0, 1'b1);
		xfer(1, 32'h2000_0000, MST_PROTO, 3'h0, 16'h2, 1'b1);
		@(posedge sys_clk);
		acw_wr_en <= 1'b1;
		acw_wr_idx <= 4'h1;
		acw_wr_data <= 32'h0000_0100;
		@(posedge sys_clk);
		acw_wr_en <= 1'b0;
		xfer(1, 32'h2000_0000, MST_PROTO, 3'h0, 16'h0, 1'b0);
		xfer(1, 32'h2000_001f, MST_EXT, 3'h0, 16'h2, 1'b1);
		chk("valid", 64'h7, desc_valid);
		dwr(4'h0, 2'h0, 32'h1000_0000);
		repeat (2) @(posedge sys_clk);
		#1;
		chk("valid", 64'h6, desc_valid);
		xfer(0, 32'h1000_0004, MST_CORE, 3'h2, 16'h0, 1'b1);
		dwr(4'h0, 2'h3, 32'h1);
		region(4'hf, 32'h0000_0000, 32'hffff_ffe0, 32'h0);
		xfer(1, 32'h3000_0000, MST_CORE, 3'h2, 16'h8000, 1'b1);
		xfer(0, 32'h1000_0004, MST_CORE, 3'h0, 16'h0, 1'b0);
		@(posedge sys_clk);
		fault_clr <= 2'h3;
		@(posedge sys_clk);
		fault_clr <= 2'h0;
		@(posedge sys_clk);
		#1;
		chk("flag", 64'h0, fault_flag);
		@(posedge sys_clk);
		wait_cycles <= {4'h5, 4'h3};
		xfer(0, 32'h1000_0008, MST_CORE, 3'h6, 16'h0, 1'b0);
		xfer(1, 32'h1000_0010, MST_DMA, 3'h0, 16'h0, 1'b0);
		@(posedge sys_clk);
		prot_enable <= 1'b0;
		repeat (3) @(posedge sys_clk);
		xfer(1, 32'h3000_0000, MST_EXT, 3'h4, 16'h0, 1'b0);
		conclude();
	end

	// Watchdog far beyond the roughly 150 cycles the sequence needs.
	initial begin
		repeat (5000) @(posedge sys_clk);
		n_fail++;
		conclude();
	end
endmodule : brac_top_tb

/* File: rtl/brac_chk_if.sv */
// Carrier between a port sequencer and its region lookup.
`timescale 1ns/1ns
interface brac_chk_if;
	import brac_pkg::*;
	logic [ADDR_W-1:0] addr;
	logic [1:0] mst;
	logic sup;
	logic fetch;
	logic wr;
	logic [MAX_REGIONS-1:0] hit;
	logic grant;

	modport seq (output addr, output mst, output sup, output fetch, output wr,
		input hit, input grant);
	modport chk (input addr, input mst, input sup, input fetch, input wr,
		output hit, output grant);
endinterface : brac_chk_if

/* File: rtl/brac_pkg.sv */
// Constants, types and decode functions for the bus region access checker.
package brac_pkg;

	localparam int ADDR_W = 32;
	localparam int DATA_W = 64;
	localparam int NUM_PORTS = 2;
	localparam int PORT_SRAM = 0;
	localparam int PORT_BRIDGE = 1;
	localparam int MAX_REGIONS = 16;
	localparam int REC_W = 64;

	// Master identifiers carried with each transfer.
	localparam logic [1:0] MST_CORE = 2'h0;
	localparam logic [1:0] MST_DMA = 2'h1;
	localparam logic [1:0] MST_PROTO = 2'h2;
	localparam logic [1:0] MST_EXT = 2'h3;

	// Word indexes inside one 128-bit descriptor.
	localparam logic [1:0] WD_START = 2'h0;
	localparam logic [1:0] WD_END = 2'h1;
	localparam logic [1:0] WD_ACW = 2'h2;
	localparam logic [1:0] WD_CTRL = 2'h3;
	localparam int CTRL_VALID_BIT = 0;

	// Region grain is 32 bytes: five low address bits are forced.
	localparam int GRAIN_BITS = 5;
	localparam logic [ADDR_W-1:0] GRAIN_MASK = 32'h0000_001f;

	// Access-control word fields.
	localparam int ACW_CORE_SUP = 0;
	localparam int ACW_CORE_USR = 3;
	localparam int ACW_DMA = 6;
	localparam int ACW_PROTO = 8;
	localparam int ACW_EXT = 10;
	localparam int RWX_R = 0;
	localparam int RWX_W = 1;
	localparam int RWX_X = 2;

	// Error record fields.
	localparam int REC_ADDR_LSB = 0;
	localparam int REC_MST_LSB = 32;
	localparam int REC_WRITE_BIT = 34;
	localparam int REC_SUP_BIT = 35;
	localparam int REC_FETCH_BIT = 36;
	localparam int REC_HIT_LSB = 40;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CHECK = 2'b01,
		ST_SLAVE = 2'b10
	} brac_state_t;

	// Rights of one access against one access-control word.
	function automatic logic brac_perm_ok(input logic [31:0] acw, input logic [1:0] mst,
			input logic sup, input logic fetch, input logic wr);
		logic [2:0] rwx;
		logic [1:0] rw;
		rwx = sup ? acw[ACW_CORE_SUP +: 3] : acw[ACW_CORE_USR +: 3];
		rw = (mst == MST_DMA) ? acw[ACW_DMA +: 2] :
			(mst == MST_PROTO) ? acw[ACW_PROTO +: 2] : acw[ACW_EXT +: 2];
		if (mst == MST_CORE) begin
			brac_perm_ok = fetch ? rwx[RWX_X] : (wr ? rwx[RWX_W] : rwx[RWX_R]);
		end else begin
			brac_perm_ok = wr ? rw[RWX_W] : rw[RWX_R];
		end
	endfunction : brac_perm_ok

endpackage : brac_pkg

/* File: rtl/brac_port_check.sv */
// Region lookup for one checked slave port.
`timescale 1ns/1ns
module brac_port_check import brac_pkg::*; #(
	parameter int NUM_REGIONS = MAX_REGIONS
) (
	// Descriptor table.
	input wire logic [NUM_REGIONS-1:0][ADDR_W-1:0] rgn_start,
	input wire logic [NUM_REGIONS-1:0][ADDR_W-1:0] rgn_end,
	input wire logic [NUM_REGIONS-1:0][31:0] rgn_acw,
	input wire logic [NUM_REGIONS-1:0] rgn_valid,
	// Transfer under test.
	brac_chk_if.chk chk
);

	logic [MAX_REGIONS-1:0] ok;

	// Each region is tested in parallel; a single cycle keeps the added latency fixed.
	for (genvar i = 0; i < MAX_REGIONS; i++) begin : g_rgn
		if (i < NUM_REGIONS) begin : g_used
			assign chk.hit[i] = rgn_valid[i] &&
				chk.addr >= (rgn_start[i] & ~GRAIN_MASK) &&
				chk.addr <= (rgn_end[i] | GRAIN_MASK);
			assign ok[i] = chk.hit[i] &&
				brac_perm_ok(rgn_acw[i], chk.mst, chk.sup, chk.fetch, chk.wr);
		end else begin : g_none
			assign chk.hit[i] = 1'b0;
			assign ok[i] = 1'b0;
		end
	end

	// Any granting region wins over any refusing one.
	assign chk.grant = |ok;

endmodule : brac_port_check

/* File: rtl/brac_top.sv */
// Bus region access checker on the SRAM and peripheral bridge slave ports.
`timescale 1ns/1ns
module brac_top import brac_pkg::*; #(
	parameter int NUM_REGIONS = MAX_REGIONS
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Protection control.
	input wire logic prot_enable,
	output logic prot_active,
	// Descriptor programming, main view.
	input wire logic desc_wr_en,
	input wire logic [3:0] desc_wr_idx,
	input wire logic [1:0] desc_wr_word,
	input wire logic [31:0] desc_wr_data,
	// Access-control word programming, alternate view.
	input wire logic acw_wr_en,
	input wire logic [3:0] acw_wr_idx,
	input wire logic [31:0] acw_wr_data,
	// Descriptor state.
	output logic [NUM_REGIONS-1:0] desc_valid,
	// Master side of each checked port.
	input wire logic [NUM_PORTS-1:0] m_valid,
	input wire logic [NUM_PORTS-1:0][ADDR_W-1:0] m_addr,
	input wire logic [NUM_PORTS-1:0] m_write,
	input wire logic [NUM_PORTS-1:0][1:0] m_master,
	input wire logic [NUM_PORTS-1:0] m_super,
	input wire logic [NUM_PORTS-1:0] m_ifetch,
	input wire logic [NUM_PORTS-1:0][DATA_W-1:0] m_wdata,
	output logic [NUM_PORTS-1:0] m_busy,
	output logic [NUM_PORTS-1:0] m_done,
	output logic [NUM_PORTS-1:0] m_err,
	output logic [NUM_PORTS-1:0][DATA_W-1:0] m_rdata,
	// Slave side of each checked port.
	output logic [NUM_PORTS-1:0] s_valid,
	output logic [NUM_PORTS-1:0][ADDR_W-1:0] s_addr,
	output logic [NUM_PORTS-1:0] s_write,
	output logic [NUM_PORTS-1:0][DATA_W-1:0] s_wdata,
	input wire logic [NUM_PORTS-1:0] s_ready,
	input wire logic [NUM_PORTS-1:0][DATA_W-1:0] s_rdata,
	// Fault reporting.
	output logic [NUM_PORTS-1:0][REC_W-1:0] err_record,
	output logic [NUM_PORTS-1:0] fault_flag,
	input wire logic [NUM_PORTS-1:0] fault_clr
);

	// The lookup serves at most sixteen regions with a four-bit index.
	if (NUM_REGIONS < 1 || NUM_REGIONS > MAX_REGIONS) begin : g_bad_regions
		$error("NUM_REGIONS must lie between 1 and 16");
	end

	// Descriptor storage: four 32-bit words per region, 128 bits in all.
	logic [NUM_REGIONS-1:0][ADDR_W-1:0] start_reg;
	logic [NUM_REGIONS-1:0][ADDR_W-1:0] end_reg;
	logic [NUM_REGIONS-1:0][31:0] acw_reg;
	logic [NUM_REGIONS-1:0][31:0] ctrl_reg;
	logic [NUM_REGIONS-1:0] valid_reg;
	logic enable_reg;

	// Global enable: cleared by reset, so nothing is restricted until software sets it.
	// It is registered once, so every transfer is judged against one settled setting.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			enable_reg <= 1'b0;
		end else begin
			enable_reg <= prot_enable;
		end
	end

	// Address and control words of the main view.
	for (genvar i = 0; i < NUM_REGIONS; i++) begin : g_desc
		logic sel;

		// One write select per region keeps the three storage processes in step.
		assign sel = desc_wr_en && (desc_wr_idx == 4'(i));

		// Start, end and control words; the access word has a process of its own.
		always_ff @(posedge sys_clk) begin
			if (sys_rst) begin
				start_reg[i] <= '0;
				end_reg[i] <= '0;
				ctrl_reg[i] <= '0;
			end else if (sel) begin
				unique case (desc_wr_word)
					WD_START: begin
						start_reg[i] <= desc_wr_data;
					end
					WD_END: begin
						end_reg[i] <= desc_wr_data;
					end
					WD_ACW: begin
					end
					WD_CTRL: begin
						ctrl_reg[i] <= desc_wr_data;
					end
				endcase
			end
		end

		// Rights change from either view; the alternate view never touches addresses.
		// A same-cycle clash goes to the alternate view, the quick path for rights changes.
		always_ff @(posedge sys_clk) begin
			if (sys_rst) begin
				acw_reg[i] <= '0;
			end else if (acw_wr_en && acw_wr_idx == 4'(i)) begin
				acw_reg[i] <= acw_wr_data;
			end else if (sel && desc_wr_word == WD_ACW) begin
				acw_reg[i] <= desc_wr_data;
			end
		end

		// A main-view write to any word but the control word retires the region until
		// the control word is written again; software finishes with that word.
		always_ff @(posedge sys_clk) begin
			if (sys_rst) begin
				valid_reg[i] <= 1'b0;
			end else if (sel) begin
				valid_reg[i] <= (desc_wr_word == WD_CTRL) ?
					desc_wr_data[CTRL_VALID_BIT] : 1'b0;
			end
		end
	end

	// Visible descriptor and enable state.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			desc_valid <= '0;
			prot_active <= 1'b0;
		end else begin
			desc_valid <= valid_reg;
			prot_active <= enable_reg;
		end
	end

	// One sequencer and one lookup per checked slave port.
	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
		brac_state_t state_reg;
		logic [ADDR_W-1:0] addr_reg;
		logic [1:0] mst_reg;
		logic sup_reg;
		logic fetch_reg;
		logic wr_reg;
		logic [DATA_W-1:0] wdata_reg;
		logic allow;
		logic forward;
		logic refuse;
		logic answered;

		brac_chk_if chk_if ();

		assign chk_if.addr = addr_reg;
		assign chk_if.mst = mst_reg;
		assign chk_if.sup = sup_reg;
		assign chk_if.fetch = fetch_reg;
		assign chk_if.wr = wr_reg;
		// With protection off every transfer passes unchecked.
		assign allow = !enable_reg || chk_if.grant;

		// Decisions shared by the answer, record and flag processes, so they never disagree.
		assign forward = (state_reg == ST_CHECK) && allow;
		assign refuse = (state_reg == ST_CHECK) && !allow;
		assign answered = (state_reg == ST_SLAVE) && s_ready[p] && s_valid[p];

		brac_port_check #(
			.NUM_REGIONS(NUM_REGIONS)
		) u_check (
			.rgn_start(start_reg),
			.rgn_end(end_reg),
			.rgn_acw(acw_reg),
			.rgn_valid(valid_reg),
			.chk(chk_if.chk)
		);

		// Transfer attributes are held for the whole check and slave phase.
		always_ff @(posedge sys_clk) begin
			if (sys_rst) begin
				addr_reg <= '0;
				mst_reg <= MST_CORE;
				sup_reg <= 1'b0;
				fetch_reg <= 1'b0;
				wr_reg <= 1'b0;
				wdata_reg <= '0;
			end else if (state_reg == ST_IDLE && m_valid[p]) begin
				addr_reg <= m_addr[p];
				mst_reg <= m_master[p];
				sup_reg <= m_super[p];
				fetch_reg <= m_ifetch[p];
				wr_reg <= m_write[p];
				wdata_reg <= m_wdata[p];
			end
		end

		// Port sequence: take, check, then either forward or refuse.
		// The check takes a whole cycle, so a decision never rests on half-settled attributes.
		always_ff @(posedge sys_clk) begin
			if (sys_rst) begin
				state_reg <= ST_IDLE;
			end else begin
				unique case (state_reg)
					ST_IDLE: begin
						if (m_valid[p]) begin
							state_reg <= ST_CHECK;
						end
					end
					ST_CHECK: begin
						state_reg <= allow ? ST_SLAVE : ST_IDLE;
					end
					ST_SLAVE: begin
						if (s_ready[p]) begin
							state_reg <= ST_IDLE;
						end
					end
					default: begin
						state_reg <= ST_IDLE;
					end
				endcase
			end
		end

		// Slave request: raised only for an allowed transfer, so a refused one never shows.
		// Its fields are loaded once and held, so the slave sees one steady request.
		always_ff @(posedge sys_clk) begin
			if (sys_rst) begin
				s_valid[p] <= 1'b0;
				s_addr[p] <= '0;
				s_write[p] <= 1'b0;
				s_wdata[p] <= '0;
			end else if (forward) begin
				s_valid[p] <= 1'b1;
				s_addr[p] <= addr_reg;
				s_write[p] <= wr_reg;
				s_wdata[p] <= wdata_reg;
			end else if (state_reg == ST_SLAVE && s_ready[p]) begin
				s_valid[p] <= 1'b0;
			end
		end

		// Master answer: a one-cycle done, with err set for a refused transfer.
		always_ff @(posedge sys_clk) begin
			if (sys_rst) begin
				m_done[p] <= 1'b0;
				m_err[p] <= 1'b0;
				m_rdata[p] <= '0;
			end else if (refuse) begin
				m_done[p] <= 1'b1;
				m_err[p] <= 1'b1;
				m_rdata[p] <= '0;
			end else if (answered) begin
				m_done[p] <= 1'b1;
				m_err[p] <= 1'b0;
				m_rdata[p] <= s_rdata[p];
			end else begin
				m_done[p] <= 1'b0;
				m_err[p] <= 1'b0;
			end
		end

		// Busy from the taking edge until the answer is given.
		// A request raised while busy is ignored, so a master must wait for the answer.
		always_ff @(posedge sys_clk) begin
			if (sys_rst) begin
				m_busy[p] <= 1'b0;
			end else if (state_reg == ST_IDLE) begin
				m_busy[p] <= m_valid[p];
			end else if (state_reg == ST_CHECK) begin
				m_busy[p] <= allow;
			end else begin
				m_busy[p] <= !(s_ready[p] && s_valid[p]);
			end
		end

		// Fault record: always the latest fault; the hit mask tells the regions touched.
		// The record tells which regions matched, not which right was missing.
		always_ff @(posedge sys_clk) begin
			if (sys_rst) begin
				err_record[p] <= '0;
			end else if (refuse) begin
				err_record[p] <= '0;
				err_record[p][REC_ADDR_LSB +: ADDR_W] <= addr_reg;
				err_record[p][REC_MST_LSB +: 2] <= mst_reg;
				err_record[p][REC_WRITE_BIT] <= wr_reg;
				err_record[p][REC_SUP_BIT] <= sup_reg;
				err_record[p][REC_FETCH_BIT] <= fetch_reg;
				err_record[p][REC_HIT_LSB +: MAX_REGIONS] <= chk_if.hit;
			end
		end

		// Sticky fault flag; a fault in the clearing cycle keeps it set.
		// Software sees it drop only when it clears in a cycle with no new fault.
		always_ff @(posedge sys_clk) begin
			if (sys_rst) begin
				fault_flag[p] <= 1'b0;
			end else if (refuse) begin
				fault_flag[p] <= 1'b1;
			end else if (fault_clr[p]) begin
				fault_flag[p] <= 1'b0;
			end
		end
	end

endmodule : brac_top
